// >>> flash_device_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_device_model import flash_host_pkg::*; #(
   parameter bit BOOT_BOTTOM = 1'b0
) (
   input wire logic [ADDR_W-1:0] addr, // address pins
   input wire logic [DATA_W-1:0] dq_host, // data pins as driven by host
   input wire logic cs_n, // chip select
   input wire logic og_n, // output gate
   input wire logic ws_n, // write strobe
   output logic [DATA_W-1:0] dq_dev, // data pins as driven by device
   output logic dq_dev_oe // device drives data pins
);
   logic [7:0] mem [0:524287];
   logic [18:0] wa;
   logic [7:0] last = 8'h00;
   logic busy = 1'b0;
   logic tog = 1'b0;
   logic fin7 = 1'b0;
   logic armed = 1'b0;
   bit boot_lock = 1'b0;
   int step = 0;
   int prog_ns = 1000;
   int erase_ns = 3000;
   int chip_ns = 6000;
   initial begin
      for (int i = 0; i < 524288; i++) begin
         mem[i] = 8'hff;
      end
   end
   function automatic logic [7:0] rd(logic [18:0] a);
      return mem[a];
   endfunction
   // 16 KB boot region, top or bottom variant
   function automatic logic in_boot(logic [18:0] a);
      return BOOT_BOTTOM ? (a < 19'h04000) : (a >= 19'h7c000);
   endfunction
   task automatic run(int t, logic b7);
      fork begin
         fin7 = b7;
         busy = 1'b1;
         #(t);
         busy = 1'b0;
      end join_none
   endtask
   task automatic wr(logic [18:0] a, logic [7:0] d);
      if (busy) begin
         step = 0;
         return;
      end
      case (step)
         0, 3: step = (a == 19'h05555 && d == 8'haa) ? step + 1 : 0;
         1, 4: step = (a == 19'h02aaa && d == 8'h55) ? step + 1 : 0;
         2: step = (a != 19'h05555) ? 0 : (d == 8'ha0) ? 6 : (d == 8'h80) ? 3 : 0;
         5: begin
            if (d == 8'h30 && !(boot_lock && in_boot(a))) begin
               for (int i = 0; i < 1024; i++) begin
                  mem[{a[18:10], 10'(i)}] = 8'hff;
               end
               run(erase_ns, 1'b1);
            end else if (d == 8'h10 && a == 19'h05555 && !boot_lock) begin
               for (int i = 0; i < 524288; i++) begin // shortened chip erase
                  mem[i] = 8'hff;
               end
               run(chip_ns, 1'b1);
            end
            step = 0;
         end
         default: begin
            if (!(boot_lock && in_boot(a))) begin
               mem[a] = rd(a) & d;
               run(prog_ns, d[7]);
            end
            step = 0;
         end
      endcase
   endtask
   // later fall latches address, earlier rise latches data, either strobe may time it
   always @(negedge (cs_n | ws_n)) begin
      // address pins change in the strobe's own time step
      #1;
      wa = addr;
      armed = 1'b1;
   end
   always @(posedge (cs_n | ws_n)) begin
      if (armed && og_n === 1'b1) wr(wa, dq_host);
      armed = 1'b0;
   end
   always @(negedge (cs_n | og_n)) begin
      if (busy) tog = ~tog;
   end
   always @(cs_n, og_n, busy, tog, addr) begin
      if (cs_n === 1'b0 && og_n === 1'b0) begin
         last = busy ? {~fin7, tog, ~last[5:0]} : rd(addr);
         dq_dev = last;
         dq_dev_oe = 1'b1;
      end else begin
         dq_dev = ~last;
         dq_dev_oe = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> flash_host.sv
// What this block does
// - read only while chip_select_n and output_gate_n are both low
// - write_strobe_n high before and throughout every read
// - byte program: two unlock writes, setup write, then location and byte
// - write timed by write_strobe_n and chip_select_n together, both dropped and raised in the same cycle
// - sector erase: unlock, setup, unlock, erase code at sector location
// - host does not erase before programming; caller erases the sector first
// - erase completion read back via bit 7 and bit 6 together (bit 6 steady, bit 7 as expected)
`timescale 1ns/100ps
`default_nettype none
module flash_host import flash_host_pkg::*; #(
   parameter logic [21:0] PROG_LIMIT = 22'(BYTE_PROGRAM_CYC),
   parameter logic [21:0] ERASE_LIMIT = 22'(SECTOR_ERASE_CYC)
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic req_valid, // request offered
   input wire host_req_t req, // operation, location, byte
   output logic req_ready, // idle, request taken
   output logic rsp_valid, // one-cycle completion pulse
   output host_rsp_t rsp, // byte read and timeout flag
   output logic [ADDR_W-1:0] flash_addr, // address pins
   output logic [DATA_W-1:0] flash_dq_out, // data pins, driven value
   output logic flash_dq_oe, // data pins driven
   input wire logic [DATA_W-1:0] flash_dq_in, // data pins, sensed value
   output logic chip_select_n, // chip select strobe
   output logic output_gate_n, // output gate strobe
   output logic write_strobe_n // write strobe
);
   typedef enum logic [2:0] {st_idle, st_wr_low, st_wr_high, st_rd_low, st_rd_high} state_t;

   logic [DATA_W-1:0] dq_meta;
   logic [DATA_W-1:0] dq_sync;
   state_t state, next_state;
   host_req_t cur, next_cur;
   logic [2:0] step, next_step;
   logic [7:0] cnt, next_cnt;
   logic [21:0] wait_cnt, next_wait_cnt;
   logic [DATA_W-1:0] rd_byte, next_rd_byte;
   logic [DATA_W-1:0] prev_byte, next_prev_byte;
   logic have_prev, next_have_prev;
   pin_out_t pins, next_pins;
   logic next_req_ready;
   logic next_rsp_valid;
   host_rsp_t next_rsp;
   logic expect7;
   logic [21:0] limit;
   logic [2:0] last_step;
   bus_word_t wr_word;

   function automatic bus_word_t seq_word(input op_t op, input logic [2:0] s, input host_req_t r);
      bus_word_t w;
      w = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
      if (s == 3'h1 || s == 3'h4) begin
         w = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2};
      end else if (s == 3'h2) begin
         w.data = (op == op_program) ? PROGRAM_SETUP_CODE : ERASE_SETUP_CODE;
      end else if (s == 3'h3 && op == op_program) begin
         w = '{addr: r.addr, data: r.data}; // caller erases the sector first
      end else if (s == 3'h5) begin
         w = '{addr: r.addr, data: SECTOR_ERASE_CODE};
      end
      return w;
   endfunction

   function automatic pin_out_t write_pins(input bus_word_t w);
      return '{addr: w.addr, data: w.data, dq_oe: 1'b1, cs_n: 1'b0, og_n: 1'b1, ws_n: 1'b0};
   endfunction

   always_ff @(posedge sys_clk) begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
   end

   assign expect7 = (cur.op == op_program) ? cur.data[POLL_BIT] : 1'b1;
   assign limit = (cur.op == op_program) ? PROG_LIMIT : ERASE_LIMIT;
   assign last_step = (cur.op == op_program) ? PROG_STEPS - 3'h1 : ERASE_STEPS - 3'h1;
   assign wr_word = seq_word(cur.op, step + 3'h1, cur);

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_step = step;
      next_cnt = cnt + 8'h1;
      next_wait_cnt = (wait_cnt < limit) ? wait_cnt + 22'h1 : wait_cnt;
      next_rd_byte = rd_byte;
      next_prev_byte = prev_byte;
      next_have_prev = have_prev;
      next_pins = pins;
      next_req_ready = req_ready;
      next_rsp_valid = 1'b0;
      next_rsp = rsp;
      case (state)
         st_idle: begin
            next_cnt = 8'h0;
            next_req_ready = 1'b1;
            if (req_valid && req_ready) begin
               next_cur = req;
               next_req_ready = 1'b0;
               next_step = 3'h0;
               next_have_prev = 1'b0;
               next_wait_cnt = 22'h0;
               if (req.op == op_read) begin
                  next_pins = '{addr: req.addr, data: pins.data, dq_oe: 1'b0, cs_n: 1'b0, og_n: 1'b0, ws_n: 1'b1};
                  next_state = st_rd_low;
               end else begin
                  next_pins = write_pins(seq_word(req.op, 3'h0, req));
                  next_state = st_wr_low;
               end
            end
         end
         st_wr_low: begin
            if (cnt == 8'(WP_CYC - 1)) begin
               next_pins.cs_n = 1'b1;
               next_pins.ws_n = 1'b1;
               next_cnt = 8'h0;
               next_state = st_wr_high;
            end
         end
         st_wr_high: begin
            next_pins.dq_oe = 1'b0;
            next_wait_cnt = 22'h0;
            if (cnt == 8'(WPH_CYC - 1)) begin
               next_cnt = 8'h0;
               if (step == last_step) begin
                  next_pins = '{addr: cur.addr, data: pins.data, dq_oe: 1'b0, cs_n: 1'b0, og_n: 1'b0, ws_n: 1'b1};
                  next_state = st_rd_low;
               end else begin
                  next_step = step + 3'h1;
                  next_pins = write_pins(wr_word);
                  next_state = st_wr_low;
               end
            end
         end
         st_rd_low: begin
            if (cnt == 8'(ACC_CYC - 1)) begin
               next_rd_byte = dq_sync;
               next_pins.cs_n = 1'b1;
               next_pins.og_n = 1'b1;
               next_cnt = 8'h0;
               next_state = st_rd_high;
            end
         end
         default: begin
            if (cnt == 8'(DF_CYC - 1)) begin
               next_cnt = 8'h0;
               if (cur.op == op_read || (have_prev && rd_byte[TOGGLE_BIT] == prev_byte[TOGGLE_BIT]
                   && rd_byte[POLL_BIT] == expect7) || wait_cnt >= limit) begin
                  next_rsp_valid = 1'b1;
                  next_rsp = '{data: rd_byte, timeout: cur.op != op_read && wait_cnt >= limit};
                  next_req_ready = 1'b1;
                  next_state = st_idle;
               end else begin
                  next_have_prev = 1'b1;
                  next_prev_byte = rd_byte;
                  next_pins.cs_n = 1'b0;
                  next_pins.og_n = 1'b0;
                  next_state = st_rd_low;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= st_idle;
         cur <= '0;
         step <= 3'h0;
         cnt <= 8'h0;
         wait_cnt <= 22'h0;
         rd_byte <= '0;
         prev_byte <= '0;
         have_prev <= 1'b0;
         pins <= '{addr: '0, data: '0, dq_oe: 1'b0, cs_n: 1'b1, og_n: 1'b1, ws_n: 1'b1};
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         step <= next_step;
         cnt <= next_cnt;
         wait_cnt <= next_wait_cnt;
         rd_byte <= next_rd_byte;
         prev_byte <= next_prev_byte;
         have_prev <= next_have_prev;
         pins <= next_pins;
         req_ready <= next_req_ready;
         rsp_valid <= next_rsp_valid;
         rsp <= next_rsp;
      end
   end

   assign flash_addr = pins.addr;
   assign flash_dq_out = pins.data;
   assign flash_dq_oe = pins.dq_oe;
   assign chip_select_n = pins.cs_n;
   assign output_gate_n = pins.og_n;
   assign write_strobe_n = pins.ws_n;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_read_write_high: assert property (!output_gate_n |-> write_strobe_n)
      else $error("write strobe low during a read");
   a_read_with_select: assert property (!output_gate_n |-> !chip_select_n && !flash_dq_oe)
      else $error("read without chip select or with data driven");
   a_read_ends_bounded: assert property ($fell(output_gate_n) |-> ##[1:40] $rose(output_gate_n) && rd_byte == $past(dq_sync))
      else $error("read cycle not closed in time");
   a_strobe_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n && !chip_select_n && flash_dq_oe) [*8])
      else $error("write strobe pulse too short");
   a_unlock_first: assert property ($fell(write_strobe_n) && step == 3'h0 |-> flash_addr == UNLOCK_ADDR1 && flash_dq_out == UNLOCK_DATA1)
      else $error("sequence does not open with unlock");
   a_prog_four: assert property ($fell(write_strobe_n) && cur.op == op_program && step == 3'h3 |-> flash_addr == cur.addr && flash_dq_out == cur.data)
      else $error("program location or byte wrong");
   a_erase_six: assert property ($fell(write_strobe_n) && cur.op == op_erase && step == 3'h5 |-> flash_dq_out == SECTOR_ERASE_CODE && flash_addr == cur.addr)
      else $error("sector erase command wrong");
   a_poll_result: assert property (rsp_valid && !rsp.timeout && cur.op != op_read |-> rsp.data[POLL_BIT] == expect7)
      else $error("completion reported with bit 7 not settled");
   a_no_extra_writes: assert property ($fell(write_strobe_n) |-> step <= last_step && cur.op != op_read)
      else $error("write cycle outside a sequence");
   c_read_done: cover property (rsp_valid && cur.op == op_read);
   c_program_done: cover property (rsp_valid && cur.op == op_program && !rsp.timeout);
   c_erase_done: cover property (rsp_valid && cur.op == op_erase && !rsp.timeout);
   c_timeout: cover property (rsp_valid && rsp.timeout);
endmodule
`default_nettype wire

// >>> flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
   localparam int CLK_NS = 4;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int T_WP_NS = 50;
   localparam int T_WPH_NS = 35;
   localparam int T_ACC_NS = 120;
   localparam int T_DF_NS = 50;
   localparam int SYNC_STAGES = 2;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int DF_CYC = (T_DF_NS + CLK_NS - 1) / CLK_NS;
   localparam int BYTE_PROGRAM_DURATION_US = 20;
   localparam int SECTOR_ERASE_DURATION_MS = 10;
   localparam int BYTE_PROGRAM_CYC = BYTE_PROGRAM_DURATION_US * 1000 / CLK_NS;
   localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_DURATION_MS * 1000000 / CLK_NS;
   localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
   localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
   localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] PROGRAM_SETUP_CODE = 8'ha0;
   localparam logic [7:0] ERASE_SETUP_CODE = 8'h80;
   localparam logic [7:0] SECTOR_ERASE_CODE = 8'h30;
   localparam logic [2:0] PROG_STEPS = 3'h4;
   localparam logic [2:0] ERASE_STEPS = 3'h6;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   typedef enum logic [1:0] {op_read, op_program, op_erase} op_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bus_word_t;
   typedef struct packed {
      op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } host_req_t;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic timeout;
   } host_rsp_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic dq_oe;
      logic cs_n;
      logic og_n;
      logic ws_n;
   } pin_out_t;
endpackage
`default_nettype wire

// >>> parallel_flash_bus_and_erase_program_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_flash_bus_and_erase_program_tb_top import flash_host_pkg::*;;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   host_req_t req = '0;
   logic req_ready, rsp_valid, flash_dq_oe, chip_select_n, output_gate_n, write_strobe_n, dev_oe;
   host_rsp_t rsp, r;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] flash_dq_out, dev_dq;
   wire logic [DATA_W-1:0] bus = flash_dq_oe ? flash_dq_out : dev_dq;
   int n_fail = 0;
   int cmp_count = 0;
   always #2 sys_clk = ~sys_clk;
   flash_host #(.PROG_LIMIT(22'd600), .ERASE_LIMIT(22'd1500)) dut (.sys_clk(sys_clk), .rst(rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(bus),
      .chip_select_n(chip_select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n));
   flash_device_model dev (.addr(flash_addr), .dq_host(flash_dq_out), .cs_n(chip_select_n),
      .og_n(output_gate_n), .ws_n(write_strobe_n), .dq_dev(dev_dq), .dq_dev_oe(dev_oe));
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic op(op_t o, logic [18:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(negedge sys_clk);
      req_valid = 1'b1;
      req = '{op: o, addr: a, data: d};
      while (req_ready !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      check("req_ready", req_ready, 1'b1);
      @(negedge sys_clk);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      check("rsp_valid", rsp_valid, 1'b1);
      r = rsp;
   endtask
   task automatic read_expect(logic [18:0] a, logic [7:0] d);
      op(op_read, a, 8'h00);
      check("read data", r.data, d);
   endtask
   task automatic s_erased();
      read_expect(19'h12345, 8'hff);
      read_expect(19'h7ffff, 8'hff);
   endtask
   // only erased locations are programmed
   task automatic s_program();
      op(op_program, 19'h00403, 8'h5a);
      check("prog timeout", r.timeout, 1'b0);
      op(op_program, 19'h00404, 8'ha5);
      check("prog timeout", r.timeout, 1'b0);
      read_expect(19'h00403, 8'h5a);
      read_expect(19'h00404, 8'ha5);
   endtask
   task automatic s_erase();
      op(op_program, 19'h00800, 8'h3c);
      op(op_erase, 19'h00400, 8'h00);
      check("erase timeout", r.timeout, 1'b0);
      read_expect(19'h00403, 8'hff);
      read_expect(19'h00404, 8'hff);
      read_expect(19'h00800, 8'h3c);
   endtask
   task automatic s_timeout();
      dev.prog_ns = 5000;
      op(op_program, 19'h01000, 8'h81);
      check("slow timeout", r.timeout, 1'b1);
      #6000;
      dev.prog_ns = 1000;
      read_expect(19'h01000, 8'h81);
   endtask
   // locked boot location: program ignored, poll never settles
   task automatic s_boot_lock();
      dev.boot_lock = 1'b1;
      op(op_program, 19'h7c010, 8'h00);
      check("locked timeout", r.timeout, 1'b1);
      dev.boot_lock = 1'b0;
      read_expect(19'h7c010, 8'hff);
   endtask
   // program offered while a slow erase still runs
   task automatic s_erase_busy();
      dev.erase_ns = 8000;
      op(op_erase, 19'h00800, 8'h00);
      check("slow erase timeout", r.timeout, 1'b1);
      op(op_program, 19'h01400, 8'h00);
      check("ignored prog timeout", r.timeout, 1'b1);
      dev.erase_ns = 3000;
      read_expect(19'h01400, 8'hff);
      read_expect(19'h00800, 8'hff);
   endtask
   always @(negedge sys_clk) begin
      if (!rst) begin
         check("bus contention", flash_dq_oe & dev_oe, 1'b0);
         if (output_gate_n === 1'b0) begin
            check("write strobe in read", write_strobe_n, 1'b1);
            check("host drive in read", flash_dq_oe, 1'b0);
         end
      end
   end
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      s_erased();
      s_program();
      s_erase();
      s_timeout();
      s_boot_lock();
      s_erase_busy();
      report_and_stop();
   end
endmodule
`default_nettype wire
